// ===== hdl/acp_dev.sv
// Converter end of the parallel port: conversion control, read-back and
// a write FIFO toward the internal register logic.
// Assumes all link inputs are synchronous to sys_clk_i.
`timescale 1ns/10ps
`include "acp_cfg.svh"

// ************************************************************
// Write FIFO
// ************************************************************
module acp_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	import acp_pkg::*;
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
		begin : g_bad
			$error("acp_fifo: DEPTH must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
	logic push, pop;

	assign push = in_valid_i & in_ready_r;
	assign pop = out_ready_i & out_valid_r;

	always_comb
	begin
		wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
		in_ready_nxt = count_nxt != (AW+1)'(DEPTH);
		out_valid_nxt = count_nxt != '0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			in_ready_r <= 1'b0;
			out_valid_r <= 1'b0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
			in_ready_r <= in_ready_nxt;
			out_valid_r <= out_valid_nxt;
		end
	end

	// Storage needs no reset; valid guards it
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	assign in_ready_o = in_ready_r;
	assign out_valid_o = out_valid_r;
	assign out_data_o = mem_r[rd_ptr_r];
endmodule : acp_fifo

// ************************************************************
// Converter end
// ************************************************************
// How it works
// R1: Busy rises after start falls, holds throughout
// R2: Busy falls only after result is loaded
// R3: Back to track on thirteenth clock edge
// R4: Thirteen clock edges plus fixed settle delay
// R5: Works with continuous or burst master clock
// R6: Start falling edge begins the conversion
// R7: Start falling edge switches track to hold
// R8: Rising start edge powers up after shutdown
// R9: Write strobe with select captures bus data
// R10: Read strobe with select drives the result
// R11: Strobes without chip select do nothing
// R12: Word mode twelve lines, byte mode eight
// R13: High byte select picks low or top bits
// R14: High byte carries channel in bits 4-6
// R15: Host writes zeros in high byte upper bits
// R16: Lines released unless select and read low
module acp_dev #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Link
	acp_link_if.dev link,
	// Analog front end
	input wire logic [`ACP_DATA_W-1:0] sample_i,
	input wire logic [`ACP_CHAN_W-1:0] channel_i,
	input wire logic auto_powerdown_i,
	// Conversion status
	output logic powered_o,
	output logic sampling_hold_o,
	output logic conv_done_o,
	// Register writes
	output logic reg_valid_o,
	input wire logic reg_ready_i,
	output logic [`ACP_DATA_W+1:0] reg_data_o,
	output logic reg_space_o
);
	import acp_pkg::*;
	localparam int FW = `ACP_DATA_W + 2;

	generate
		if (`ACP_T2_CYC < 1 || `ACP_CONV_EDGES > 15)
		begin : g_bad
			$error("acp_dev: timing constants out of range");
		end
	endgenerate

	// Byte lane selection for a read
	function automatic logic [`ACP_DATA_W-1:0] acp_pick(
		input logic [`ACP_DATA_W-1:0] res,
		input logic [`ACP_CHAN_W-1:0] chan,
		input logic word,
		input logic hb
	);
		logic [`ACP_DATA_W-1:0] v;
		v = '0;
		if (word)
			v = res; // R12
		else if (!hb)
			v[`ACP_BYTE_W-1:0] = res[`ACP_BYTE_W-1:0]; // R13
		else
		begin
			v[`ACP_DATA_W-`ACP_HI_NIB_LSB-1:0] = res[`ACP_DATA_W-1:`ACP_HI_NIB_LSB]; // R13
			v[`ACP_CHAN_LSB +: `ACP_CHAN_W] = chan; // R14
		end
		return v;
	endfunction : acp_pick

	acp_dev_state_t state_r, state_nxt;
	logic start_q_r, mclk_q_r, wr_q_r;
	logic busy_r, busy_nxt, hold_r, hold_nxt, powered_r, powered_nxt;
	logic done_r, done_nxt;
	logic [3:0] edge_cnt_r, edge_cnt_nxt, settle_cnt_r, settle_cnt_nxt;
	logic [`ACP_DATA_W-1:0] held_r, held_nxt, result_r, result_nxt;
	logic [`ACP_CHAN_W-1:0] held_chan_r, held_chan_nxt, res_chan_r, res_chan_nxt;
	logic [`ACP_DATA_W-1:0] dev_d_r, dev_d_nxt, dev_oe_r, dev_oe_nxt;
	logic start_fall, start_rise, mclk_rise, wr_take, rd_act;
	logic fifo_ready, space_r;

	assign start_fall = start_q_r & ~link.conversion_start_n;
	assign start_rise = ~start_q_r & link.conversion_start_n;
	// Only edges count, so a stopped burst clock just pauses the count
	assign mclk_rise = ~mclk_q_r & link.master_conv_clock; // R5
	assign rd_act = ~link.cs_n & ~link.rd_n; // R11
	assign wr_take = wr_q_r & ~link.wr_n & ~link.cs_n; // R9 R11

	// ************************************************************
	// Conversion sequencer
	// ************************************************************
	always_comb
	begin
		state_nxt = state_r;
		busy_nxt = busy_r;
		hold_nxt = hold_r;
		powered_nxt = powered_r;
		done_nxt = 1'b0;
		edge_cnt_nxt = edge_cnt_r;
		settle_cnt_nxt = settle_cnt_r;
		held_nxt = held_r;
		held_chan_nxt = held_chan_r;
		result_nxt = result_r;
		res_chan_nxt = res_chan_r;
		case (state_r)
			ACP_D_IDLE:
			begin
				if (powered_r && start_fall)
				begin
					hold_nxt = 1'b1; // R7
					held_nxt = sample_i; // R7
					held_chan_nxt = channel_i;
					busy_nxt = 1'b1; // R1 R6
					edge_cnt_nxt = '0;
					state_nxt = ACP_D_CONV; // R6
				end
				else if (!powered_r && start_rise)
					powered_nxt = 1'b1; // R8
			end
			ACP_D_CONV:
			begin
				if (mclk_rise)
				begin
					edge_cnt_nxt = edge_cnt_r + 1'b1; // R4
					if (edge_cnt_r == 4'(`ACP_CONV_EDGES - 1))
					begin
						hold_nxt = 1'b0; // R3
						result_nxt = held_r; // R2
						res_chan_nxt = held_chan_r;
						settle_cnt_nxt = '0;
						state_nxt = ACP_D_SETTLE;
					end
				end
			end
			ACP_D_SETTLE:
			begin
				settle_cnt_nxt = settle_cnt_r + 1'b1; // R4
				if (settle_cnt_r == 4'(`ACP_T2_CYC - 1))
				begin
					busy_nxt = 1'b0; // R2
					done_nxt = 1'b1;
					if (auto_powerdown_i)
						powered_nxt = 1'b0;
					state_nxt = ACP_D_IDLE;
				end
			end
			default:
			begin
				state_nxt = ACP_D_IDLE;
				busy_nxt = 1'b0;
				hold_nxt = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Read drive
	// ************************************************************
	always_comb
	begin
		dev_d_nxt = '0;
		dev_oe_nxt = '0; // R16
		if (rd_act)
		begin
			dev_d_nxt = acp_pick(result_r, res_chan_r, link.word_mode,
				link.high_byte_select); // R10
			dev_oe_nxt = link.word_mode ? '1 : `ACP_DATA_W'(8'hff); // R12
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			state_r <= ACP_D_IDLE;
			start_q_r <= 1'b1;
			mclk_q_r <= 1'b0;
			wr_q_r <= 1'b1;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			powered_r <= `ACP_POWERED_RST;
			done_r <= 1'b0;
			edge_cnt_r <= '0;
			settle_cnt_r <= '0;
			held_r <= '0;
			held_chan_r <= '0;
			result_r <= '0;
			res_chan_r <= '0;
			dev_d_r <= '0;
			dev_oe_r <= '0;
			space_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			start_q_r <= link.conversion_start_n;
			mclk_q_r <= link.master_conv_clock;
			wr_q_r <= link.wr_n;
			busy_r <= busy_nxt;
			hold_r <= hold_nxt;
			powered_r <= powered_nxt;
			done_r <= done_nxt;
			edge_cnt_r <= edge_cnt_nxt;
			settle_cnt_r <= settle_cnt_nxt;
			held_r <= held_nxt;
			held_chan_r <= held_chan_nxt;
			result_r <= result_nxt;
			res_chan_r <= res_chan_nxt;
			dev_d_r <= dev_d_nxt;
			dev_oe_r <= dev_oe_nxt;
			space_r <= fifo_ready;
		end
	end

	// ************************************************************
	// Register write path
	// ************************************************************
	// A write arriving while full is dropped; reg_space_o warns the host
	acp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(wr_take), // R9
		.in_ready_o(fifo_ready),
		.in_data_i({~link.word_mode, link.high_byte_select & ~link.word_mode,
			link.data_lines}),
		.out_valid_o(reg_valid_o),
		.out_ready_i(reg_ready_i),
		.out_data_o(reg_data_o)
	);

	assign link.busy = busy_r;
	assign link.dev_d = dev_d_r;
	assign link.dev_oe = dev_oe_r;
	assign powered_o = powered_r;
	assign sampling_hold_o = hold_r;
	assign conv_done_o = done_r;
	assign reg_space_o = space_r;
endmodule : acp_dev

// ===== hdl/acp_cfg.svh
// Timing counts and field positions for the converter parallel port.
// Assumes a 100 MHz system clock on both ends.
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// ************************************************************
// Clock
// ************************************************************
`define ACP_CLK_NS 10

// ************************************************************
// Conversion timing
// ************************************************************
`define ACP_CONV_EDGES 13
`define ACP_T2_NS 20
`define ACP_T2_CYC ((`ACP_T2_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)

// ************************************************************
// Host strobe timing
// ************************************************************
`define ACP_CONVERSION_START_N_LOW_NS 20
`define ACP_CONVERSION_START_N_LOW_CYC ((`ACP_CONVERSION_START_N_LOW_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_RD_NS 30
`define ACP_RD_CYC ((`ACP_RD_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_WR_NS 20
`define ACP_WR_CYC ((`ACP_WR_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_MCLK_HALF_CYC 2

// ************************************************************
// Data line fields
// ************************************************************
`define ACP_DATA_W 12
`define ACP_CHAN_W 3
`define ACP_BYTE_W 8
`define ACP_HB_BIT 8
`define ACP_CHAN_LSB 4
`define ACP_HI_NIB_LSB 8
`define ACP_POWERED_RST 1'b1

`endif

// ===== hdl/acp_pkg.sv
// Types shared by both ends of the converter parallel port.
// Assumes acp_cfg.svh for all numeric constants.
package acp_pkg;

	typedef enum logic [1:0] {
		ACP_D_IDLE = 2'b00,
		ACP_D_CONV = 2'b01,
		ACP_D_SETTLE = 2'b10
	} acp_dev_state_t;

	typedef enum logic [2:0] {
		ACP_H_IDLE = 3'b000,
		ACP_H_CONV = 3'b001,
		ACP_H_READ = 3'b010,
		ACP_H_GAP = 3'b011,
		ACP_H_WRITE = 3'b100
	} acp_host_state_t;

endpackage : acp_pkg

// ===== hdl/acp_link_if.sv
// Parallel port wires between converter and host.
// Assumes per-bit output enables; no end ever drives high impedance.
`timescale 1ns/10ps
`include "acp_cfg.svh"

interface acp_link_if;
	logic conversion_start_n;
	logic master_conv_clock;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic word_mode;
	logic busy;
	logic [`ACP_DATA_W-1:0] host_d;
	logic [`ACP_DATA_W-1:0] host_oe;
	logic [`ACP_DATA_W-1:0] dev_d;
	logic [`ACP_DATA_W-1:0] dev_oe;
	logic [`ACP_DATA_W-1:0] data_lines;
	logic [`ACP_BYTE_W-1:0] data_lines_low;
	logic high_byte_select;

	// Device wins a clash; during a read the host drives only bit 8, in byte mode
	assign data_lines = (dev_d & dev_oe) | (host_d & host_oe & ~dev_oe);
	assign data_lines_low = data_lines[`ACP_BYTE_W-1:0];
	assign high_byte_select = data_lines[`ACP_HB_BIT];

	modport dev (
		input conversion_start_n, master_conv_clock, cs_n, rd_n, wr_n, word_mode,
		input data_lines, data_lines_low, high_byte_select,
		output busy, dev_d, dev_oe
	);

	modport host (
		output conversion_start_n, master_conv_clock, cs_n, rd_n, wr_n, word_mode,
		output host_d, host_oe,
		input busy, data_lines, data_lines_low
	);
endinterface : acp_link_if

// ===== hdl/acp_host.sv
// Host end of the converter parallel port: start pulses, master clock,
// word or byte reads and register writes.
// Assumes all link inputs are synchronous to sys_clk_i.
`timescale 1ns/10ps
`include "acp_cfg.svh"

module acp_host (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Link
	acp_link_if.host link,
	// Mode
	input wire logic word_mode_i,
	input wire logic burst_clock_i,
	// Requests
	input wire logic start_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [`ACP_DATA_W-1:0] wr_data_i,
	input wire logic wr_high_i,
	// Answers
	output logic ready_o,
	output logic busy_o,
	output logic result_valid_o,
	output logic [`ACP_DATA_W-1:0] result_o,
	output logic [`ACP_CHAN_W-1:0] chan_o
);
	import acp_pkg::*;

	generate
		if (`ACP_RD_CYC < 2 || `ACP_MCLK_HALF_CYC < 1)
		begin : g_bad
			$error("acp_host: read strobe too short for registered drive");
		end
	endgenerate

	// Write lane layout; upper bits of the high byte kept zero
	function automatic logic [`ACP_DATA_W-1:0] acp_lane(
		input logic [`ACP_DATA_W-1:0] d,
		input logic word,
		input logic hb
	);
		logic [`ACP_DATA_W-1:0] v;
		v = '0;
		if (word)
			v = d;
		else if (!hb)
			v[`ACP_BYTE_W-1:0] = d[`ACP_BYTE_W-1:0];
		else
			v[`ACP_DATA_W-`ACP_HI_NIB_LSB-1:0] = d[`ACP_DATA_W-1:`ACP_HI_NIB_LSB]; // R15
		v[`ACP_HB_BIT] = word ? v[`ACP_HB_BIT] : hb; // R13
		return v;
	endfunction : acp_lane

	acp_host_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [3:0] div_r, div_nxt;
	logic mclk_r, mclk_nxt;
	logic start_n_r, start_n_nxt, cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
	logic hb_r, hb_nxt, word_r, word_nxt;
	logic [`ACP_DATA_W-1:0] hd_r, hd_nxt, hoe_r, hoe_nxt, wdat_r, wdat_nxt;
	logic [`ACP_DATA_W-1:0] res_r, res_nxt;
	logic [`ACP_CHAN_W-1:0] chan_r, chan_nxt;
	logic rv_r, rv_nxt, busy_r, rdy_r, rdy_nxt;
	logic run;

	// ************************************************************
	// Master clock divider
	// ************************************************************
	// Burst mode stops the clock low outside conversions
	assign run = ~burst_clock_i | link.busy | (state_r == ACP_H_CONV); // R5
	always_comb
	begin
		div_nxt = div_r + 1'b1;
		mclk_nxt = mclk_r;
		if (!run)
		begin
			div_nxt = '0;
			mclk_nxt = 1'b0;
		end
		else if (div_r == 4'(`ACP_MCLK_HALF_CYC - 1))
		begin
			div_nxt = '0;
			mclk_nxt = ~mclk_r;
		end
	end

	// ************************************************************
	// Strobe sequencer
	// ************************************************************
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 1'b1;
		start_n_nxt = 1'b1;
		cs_n_nxt = 1'b1;
		rd_n_nxt = 1'b1;
		wr_n_nxt = 1'b1;
		hb_nxt = hb_r;
		word_nxt = word_r;
		wdat_nxt = wdat_r;
		res_nxt = res_r;
		chan_nxt = chan_r;
		rv_nxt = 1'b0;
		hoe_nxt = '0;
		case (state_r)
			ACP_H_IDLE:
			begin
				cnt_nxt = '0;
				word_nxt = word_mode_i;
				if (start_i)
				begin
					start_n_nxt = 1'b0; // R6 R8
					state_nxt = ACP_H_CONV;
				end
				else if (read_i)
				begin
					hb_nxt = 1'b0;
					cs_n_nxt = 1'b0; // R11
					rd_n_nxt = 1'b0;
					state_nxt = ACP_H_READ;
				end
				else if (write_i)
				begin
					hb_nxt = wr_high_i;
					wdat_nxt = wr_data_i;
					cs_n_nxt = 1'b0; // R11
					wr_n_nxt = 1'b0; // R9
					hoe_nxt = word_mode_i ? '1 : `ACP_DATA_W'(12'h1ff);
					state_nxt = ACP_H_WRITE;
				end
			end
			ACP_H_CONV:
			begin
				start_n_nxt = 1'b0;
				if (cnt_r == 4'(`ACP_CONVERSION_START_N_LOW_CYC - 1))
				begin
					start_n_nxt = 1'b1;
					state_nxt = ACP_H_IDLE;
				end
			end
			ACP_H_READ:
			begin
				cs_n_nxt = 1'b0; // R11
				rd_n_nxt = 1'b0;
				if (cnt_r == 4'(`ACP_RD_CYC - 1))
				begin
					cs_n_nxt = 1'b1;
					rd_n_nxt = 1'b1;
					cnt_nxt = '0;
					state_nxt = ACP_H_GAP;
					if (word_r)
					begin
						res_nxt = link.data_lines; // R12
						chan_nxt = '0;
						rv_nxt = 1'b1;
					end
					else if (!hb_r)
						res_nxt[`ACP_BYTE_W-1:0] = link.data_lines_low; // R13
					else
					begin
						res_nxt[`ACP_DATA_W-1:`ACP_HI_NIB_LSB] =
							link.data_lines_low[`ACP_DATA_W-`ACP_HI_NIB_LSB-1:0]; // R13
						chan_nxt = link.data_lines_low[`ACP_CHAN_LSB +: `ACP_CHAN_W]; // R14
						rv_nxt = 1'b1;
					end
				end
			end
			ACP_H_GAP:
			begin
				// One idle cycle lets the device release the lines
				state_nxt = ACP_H_IDLE;
				// A write still shows wr low here; only a low byte read goes on
				if (!word_r && !hb_r && wr_n_r)
				begin
					cnt_nxt = '0;
					hb_nxt = 1'b1;
					cs_n_nxt = 1'b0;
					rd_n_nxt = 1'b0;
					state_nxt = ACP_H_READ;
				end
			end
			ACP_H_WRITE:
			begin
				cs_n_nxt = 1'b0; // R11
				wr_n_nxt = 1'b0;
				hoe_nxt = word_r ? '1 : `ACP_DATA_W'(12'h1ff);
				if (cnt_r == 4'(`ACP_WR_CYC - 2))
				begin
					cnt_nxt = '0;
					state_nxt = ACP_H_GAP;
				end
			end
			default:
				state_nxt = ACP_H_IDLE;
		endcase
		hd_nxt = acp_lane(wdat_nxt, word_nxt, hb_nxt);
		if (!word_nxt)
			hoe_nxt[`ACP_HB_BIT] = 1'b1; // R13
		rdy_nxt = state_nxt == ACP_H_IDLE;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			state_r <= ACP_H_IDLE;
			cnt_r <= '0;
			div_r <= '0;
			mclk_r <= 1'b0;
			start_n_r <= 1'b1;
			cs_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			hb_r <= 1'b0;
			word_r <= 1'b1;
			wdat_r <= '0;
			hd_r <= '0;
			hoe_r <= '0;
			res_r <= '0;
			chan_r <= '0;
			rv_r <= 1'b0;
			busy_r <= 1'b0;
			rdy_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			mclk_r <= mclk_nxt;
			start_n_r <= start_n_nxt;
			cs_n_r <= cs_n_nxt;
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			hb_r <= hb_nxt;
			word_r <= word_nxt;
			wdat_r <= wdat_nxt;
			hd_r <= hd_nxt;
			hoe_r <= hoe_nxt;
			res_r <= res_nxt;
			chan_r <= chan_nxt;
			rv_r <= rv_nxt;
			busy_r <= link.busy;
			rdy_r <= rdy_nxt;
		end
	end

	assign link.conversion_start_n = start_n_r;
	assign link.master_conv_clock = mclk_r;
	assign link.cs_n = cs_n_r;
	assign link.rd_n = rd_n_r;
	assign link.wr_n = wr_n_r;
	assign link.word_mode = word_r;
	assign link.host_d = hd_r;
	assign link.host_oe = hoe_r;
	assign ready_o = rdy_r;
	assign busy_o = busy_r;
	assign result_valid_o = rv_r;
	assign result_o = res_r;
	assign chan_o = chan_r;
endmodule : acp_host

// ===== testbench/acp_link_properties.sv
// Checker on the converter port wires.
// Assumes one clock; takes the interface signals as plain inputs.
`timescale 1ns/10ps
`include "acp_cfg.svh"

module acp_link_properties (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Link
	input wire logic conversion_start_n,
	input wire logic master_conv_clock,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic word_mode,
	input wire logic busy,
	input wire logic high_byte_select,
	input wire logic [`ACP_DATA_W-1:0] dev_oe,
	input wire logic [`ACP_DATA_W-1:0] data_lines
);
	logic mclk_r;
	logic mclk_nxt;
	logic [3:0] rise_r;
	logic [3:0] rise_nxt;
	logic rise;

	// ****
	// Master clock rises seen while busy
	// ****
	assign rise = master_conv_clock && !mclk_r;
	always_comb
	begin
		mclk_nxt = master_conv_clock;
		rise_nxt = rise_r;
		if (!busy)
			rise_nxt = 4'h0;
		else if (rise)
			rise_nxt = rise_r + 4'h1;
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			mclk_r <= 1'b0;
			rise_r <= 4'h0;
		end
		else
		begin
			mclk_r <= mclk_nxt;
			rise_r <= rise_nxt;
		end
	end

	// ****
	// Properties
	// ****
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_settle;
		busy ##1 busy ##1 !busy;
	endsequence
	sequence s_start_low;
		!conversion_start_n ##1 conversion_start_n;
	endsequence
	sequence s_rd_low;
		!rd_n ##1 !rd_n ##1 rd_n;
	endsequence

	a_busy_cause: assert property (
		$rose(busy) |-> !$past(conversion_start_n) && $past(conversion_start_n, 2))
		else $error("busy rose without a start edge");
	a_conv_count: assert property (
		$fell(busy) |-> rise_r == 4'hd)
		else $error("busy fell after a wrong clock count");
	a_settle_delay: assert property (
		busy && rise && rise_r == 4'hc |-> ##1 s_settle)
		else $error("busy fall not two cycles after last clock");
	a_start_pulse: assert property (
		$fell(conversion_start_n) |-> ##1 s_start_low)
		else $error("start pulse length wrong");
	a_read_strobe: assert property (
		$fell(rd_n) |-> ##1 s_rd_low)
		else $error("read strobe length wrong");
	a_oe_word: assert property (
		!cs_n && !rd_n && word_mode |=> dev_oe == 12'hfff)
		else $error("word read not driven on all lines");
	a_oe_byte: assert property (
		!cs_n && !rd_n && !word_mode |=> dev_oe[8:0] == 9'h0ff)
		else $error("byte read drives wrong lines");
	a_oe_release: assert property (
		cs_n || rd_n |=> dev_oe == 12'h000)
		else $error("lines driven outside a read");
	a_select_held: assert property (
		!rd_n || !wr_n |-> !cs_n)
		else $error("strobe without chip select");
	a_high_zero: assert property (
		!cs_n && !wr_n && !word_mode && high_byte_select |-> data_lines[7:4] == 4'h0)
		else $error("high byte write upper bits not zero");
endmodule : acp_link_properties

// ===== testbench/test_adc_conversion_parallel_port.sv
// Testbench joining the converter end and the host end.
// Assumes the link interface and both ends compiled before it.
`timescale 1ns/10ps

module test_adc_conversion_parallel_port;
	logic sys_clk_i;
	logic nrst_i;
	logic [11:0] sample_i;
	logic [11:0] wr_data_i;
	logic [11:0] result_o;
	logic [13:0] reg_data_o;
	logic [2:0] channel_i;
	logic [2:0] chan_o;
	logic [2:0] req_v;
	logic auto_powerdown_i, reg_ready_i, word_mode_i, burst_clock_i, wr_high_i;
	logic powered_o, sampling_hold_o, conv_done_o, reg_valid_o, reg_space_o;
	logic ready_o, busy_o, result_valid_o;
	int bad_count;
	int cmp_count;
	logic [11:0] exp_q[$];

	// ****
	// Ends and checker
	// ****
	acp_link_if link();
	acp_dev #(.FIFO_DEPTH(8)) acp_dev_i (.sys_clk_i, .nrst_i, .link, .sample_i, .channel_i,
		.auto_powerdown_i, .powered_o, .sampling_hold_o, .conv_done_o, .reg_valid_o,
		.reg_ready_i, .reg_data_o, .reg_space_o);
	acp_host acp_host_i (.sys_clk_i, .nrst_i, .link, .word_mode_i, .burst_clock_i,
		.start_i(req_v[0]), .read_i(req_v[1]), .write_i(req_v[2]), .wr_data_i, .wr_high_i,
		.ready_o, .busy_o, .result_valid_o, .result_o, .chan_o);
	acp_link_properties acp_link_properties_i (.sys_clk_i, .nrst_i,
		.conversion_start_n(link.conversion_start_n), .master_conv_clock(link.master_conv_clock),
		.cs_n(link.cs_n), .rd_n(link.rd_n), .wr_n(link.wr_n), .word_mode(link.word_mode),
		.busy(link.busy), .high_byte_select(link.high_byte_select), .dev_oe(link.dev_oe),
		.data_lines(link.data_lines));

	always #5 sys_clk_i = ~sys_clk_i;

	// ****
	// Helpers
	// ****
	task automatic chk_bit(input logic got, input logic exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk_bit

	task automatic chk_vec(input logic [13:0] got, input logic [13:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s got %h", $time, m, got);
		end
	endtask : chk_vec

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic wait_for(input int s);
		int n = 0;
		logic hit = 1'b0;
		while (!hit)
		begin
			@(negedge sys_clk_i);
			case (s)
				0: hit = ready_o === 1'b1;
				1: hit = result_valid_o === 1'b1;
				2: hit = conv_done_o === 1'b1;
				3: hit = link.busy === 1'b1;
				default: hit = reg_valid_o === 1'b1;
			endcase
			n++;
			if (n > 500)
			begin
				bad_count++;
				$display("mismatch at %0t: wait %0d timed out", $time, s);
				give_verdict();
			end
		end
	endtask : wait_for

	task automatic issue(input logic [2:0] m);
		wait_for(0);
		@(posedge sys_clk_i);
		req_v <= m;
		@(posedge sys_clk_i);
		req_v <= 3'b000;
	endtask : issue

	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		repeat (3) @(negedge sys_clk_i);
		chk_bit(link.busy, 1'b0, "busy after reset");
		chk_bit(sampling_hold_o, 1'b0, "hold after reset");
		chk_bit(powered_o, 1'b1, "powered after reset");
		chk_bit(reg_valid_o, 1'b0, "fifo valid after reset");
		chk_bit(reg_space_o, 1'b1, "fifo space after reset");
		chk_vec({2'b00, link.dev_oe}, 14'h0000, "lines driven after reset");
		$display("test reset done");
	endtask : t_reset

	task automatic t_conv(input logic bm, input logic wm, input logic [11:0] s,
		input logic [2:0] c);
		logic m0;
		@(posedge sys_clk_i);
		burst_clock_i <= bm;
		word_mode_i <= wm;
		sample_i <= s;
		channel_i <= c;
		issue(3'b001);
		wait_for(3);
		chk_bit(sampling_hold_o, 1'b1, "hold not set at start");
		chk_bit(busy_o, 1'b0, "host busy copy early");
		// Inputs move after the start edge; the result must not follow
		@(posedge sys_clk_i);
		sample_i <= ~s;
		channel_i <= ~c;
		wait_for(2);
		chk_bit(link.busy, 1'b0, "busy high at done");
		chk_bit(busy_o, 1'b1, "host busy copy not delayed");
		chk_bit(sampling_hold_o, 1'b0, "hold still set at done");
		repeat (2) @(negedge sys_clk_i);
		m0 = link.master_conv_clock;
		repeat (12)
		begin
			@(negedge sys_clk_i);
			if (bm)
				chk_bit(link.master_conv_clock, m0, "burst clock ran idle");
		end
		issue(3'b010);
		wait_for(1);
		chk_vec({2'b00, result_o}, {2'b00, s}, "result");
		chk_vec({11'h000, chan_o}, {11'h000, wm ? 3'h0 : c}, "channel");
		$display("test conversion done");
	endtask : t_conv

	task automatic t_fifo;
		logic [11:0] d;
		logic [3:0] n = 4'h0;
		@(posedge sys_clk_i);
		reg_ready_i <= 1'b0;
		word_mode_i <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			@(posedge sys_clk_i);
			d = 12'ha50 ^ 12'(i * 7);
			wr_data_i <= d;
			if (i < 8)
				exp_q.push_back(d);
			issue(3'b100);
		end
		repeat (4) @(negedge sys_clk_i);
		chk_bit(reg_space_o, 1'b0, "fifo not full");
		@(posedge sys_clk_i);
		reg_ready_i <= 1'b1;
		repeat (20)
		begin
			@(negedge sys_clk_i);
			if (reg_valid_o === 1'b1 && exp_q.size() > 0)
			begin
				d = exp_q.pop_front();
				n++;
				chk_vec({reg_data_o[13], 1'b0, reg_data_o[11:0]}, {2'b00, d}, "fifo word");
			end
		end
		chk_vec({10'h000, n}, 14'h0008, "fifo count");
		chk_bit(reg_valid_o, 1'b0, "fifo not empty");
		@(posedge sys_clk_i);
		word_mode_i <= 1'b0;
		wr_data_i <= 12'h9c3;
		for (int h = 0; h < 2; h++)
		begin
			@(posedge sys_clk_i);
			wr_high_i <= h[0];
			issue(3'b100);
			wait_for(4);
			d = h ? 12'h109 : 12'h0c3;
			chk_vec({reg_data_o[13:12], 3'b000, reg_data_o[8:0]}, {1'b1, h[0], 3'b000, d[8:0]},
				"byte write");
		end
		$display("test fifo done");
	endtask : t_fifo

	task automatic t_wake;
		@(posedge sys_clk_i);
		auto_powerdown_i <= 1'b1;
		t_conv(1'b0, 1'b1, 12'h5a6, 3'h4);
		chk_bit(powered_o, 1'b0, "still powered");
		@(posedge sys_clk_i);
		auto_powerdown_i <= 1'b0;
		issue(3'b001);
		repeat (6) @(negedge sys_clk_i);
		chk_bit(link.busy, 1'b0, "start converted while asleep");
		chk_bit(powered_o, 1'b1, "no wake on start rise");
		t_conv(1'b1, 1'b0, 12'h0f1, 3'h6);
		$display("test wake done");
	endtask : t_wake

	initial
	begin
		sys_clk_i = 1'b0;
		nrst_i = 1'b0;
		sample_i = 12'h000;
		wr_data_i = 12'h000;
		channel_i = 3'h0;
		req_v = 3'b000;
		{auto_powerdown_i, reg_ready_i, burst_clock_i, wr_high_i} = 4'h0;
		word_mode_i = 1'b1;
		bad_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_conv(1'b0, 1'b1, 12'ha5c, 3'h5);
		t_conv(1'b1, 1'b0, 12'h3e7, 3'h2);
		t_conv(1'b0, 1'b0, 12'hfff, 3'h7);
		t_conv(1'b1, 1'b1, 12'h000, 3'h0);
		t_fifo();
		t_wake();
		give_verdict();
	end
endmodule : test_adc_conversion_parallel_port
